// >>> ecppc_defs.svh
// constants of the ecp parallel port core: offsets, fields, reset values, timing
// assumes a 40 MHz clk and an isa-style byte window at the port base
`ifndef ECPPC_DEFS_SVH
`define ECPPC_DEFS_SVH

`define ECPPC_OFS_DATA   11'h000
`define ECPPC_OFS_STAT   11'h001
`define ECPPC_OFS_CTL    11'h002
`define ECPPC_OFS_FIFO   11'h400
`define ECPPC_OFS_CFGB   11'h401
`define ECPPC_OFS_XCTL   11'h402

`define ECPPC_WORD_W     8
`define ECPPC_FIFO_D     16
`define ECPPC_CNT_W      5

`define ECPPC_CTL_DIR    5
`define ECPPC_CTL_ACKEN  4
`define ECPPC_CTL_SELIN  3
`define ECPPC_CTL_INIT   2
`define ECPPC_CTL_AFD    1
`define ECPPC_CTL_STB    0
`define ECPPC_X_ERRN     4
`define ECPPC_X_DMA      3
`define ECPPC_X_SVC      2
`define ECPPC_TAG_BIT    7

`define ECPPC_CTL_RST    6'h00
`define ECPPC_DATA_RST   8'h00
`define ECPPC_ERRN_RST   1'b1
`define ECPPC_SVC_RST    1'b1
`define ECPPC_CFGA_VAL   8'h10
`define ECPPC_COMPRESS   1'b0
`define ECPPC_SVC_LEVEL  5'h08

`define ECPPC_CLK_MHZ    40
`define ECPPC_SETUP_NS   500
`define ECPPC_STROBE_NS  500
`define ECPPC_SETUP_CYC  ((`ECPPC_SETUP_NS * `ECPPC_CLK_MHZ + 999) / 1000)
`define ECPPC_STROBE_CYC ((`ECPPC_STROBE_NS * `ECPPC_CLK_MHZ + 999) / 1000)

`endif

// >>> ecppc_pkg.sv
// types of the ecp parallel port core
// assumes ecppc_defs.svh for the numeric constants
package ecppc_pkg;

  typedef enum logic [2:0] {
    ECPPC_STD   = 3'b000,
    ECPPC_BIDIR = 3'b001,
    ECPPC_PFIFO = 3'b010,
    ECPPC_ECP   = 3'b011,
    ECPPC_EPP   = 3'b100,
    ECPPC_RSVD  = 3'b101,
    ECPPC_TEST  = 3'b110,
    ECPPC_CFG   = 3'b111
  } ecppc_mode_e;

  typedef enum logic [2:0] {
    F_IDLE    = 3'b000,
    F_SETUP   = 3'b001,
    F_STROBE  = 3'b010,
    F_RELEASE = 3'b011
  } ecppc_fwd_e;

  typedef enum logic [1:0] {
    R_IDLE   = 2'b00,
    R_REQ    = 2'b01,
    R_HOLD   = 2'b10,
    R_REPEAT = 2'b11
  } ecppc_rev_e;

endpackage

// >>> ecppc_core.sv
// ecp parallel port core: shared queue and the port engine
// assumes synchronous isa strobes and cable inputs already in the clk domain
`timescale 1ns/1ps
`include "ecppc_defs.svh"

module ecppc_fifo #(
  parameter int W = 9,
  parameter int D = 16,
  parameter int CW = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          flush,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [CW-1:0]      count
);
  logic [W-1:0]  mem [D];
  logic [CW-1:0] wp;
  logic [CW-1:0] rp;
  wire           do_push = in_valid & in_ready;
  wire           do_pop  = out_valid & out_ready;

  assign count     = wp - rp;
  assign in_ready  = (count != CW'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp[CW-2:0]];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp[CW-2:0]] <= in_data;
    end
  end

  // pointers carry one extra bit so full and empty differ
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= wp + CW'(do_push);
      rp <= rp + CW'(do_pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module ecppc_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        aen,
  input  wire logic [10:0] io_addr,
  input  wire logic        io_rd_n,
  input  wire logic        io_wr_n,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_oe_n,
  output logic             drq,
  input  wire logic        dack_n,
  input  wire logic        irq_level,
  output logic             ack_irq,
  output logic             err_irq,
  output logic             svc_irq,
  input  wire logic [7:0]  pd_in,
  output logic      [7:0]  pd_out,
  output logic             pd_oe_n,
  output logic             strobe_n,
  output logic             autofd_n,
  output logic             init_n,
  output logic             select_in_n,
  input  wire logic        busy,
  input  wire logic        ack_n,
  input  wire logic        perror,
  input  wire logic        select,
  input  wire logic        fault_n
);
  localparam int CW = `ECPPC_CNT_W;
  localparam logic [4:0] SETUP_CYC  = 5'(`ECPPC_SETUP_CYC);
  localparam logic [4:0] STROBE_CYC = 5'(`ECPPC_STROBE_CYC);

  ecppc_pkg::ecppc_mode_e mode;
  ecppc_pkg::ecppc_fwd_e  fs;
  ecppc_pkg::ecppc_fwd_e  next_fs;
  ecppc_pkg::ecppc_rev_e  rs;
  ecppc_pkg::ecppc_rev_e  next_rs;

  logic [5:0]    ctl;
  logic [7:0]    data_reg;
  logic          err_dis;
  logic          dma_en;
  logic          svc;
  logic [7:0]    last_rd;
  logic          rd_q;
  logic          wr_q;
  logic          ack_q;
  logic [7:0]    fwd_byte;
  logic          fwd_tag;
  logic [4:0]    tmr;
  logic [7:0]    rev_byte;
  logic          rev_cmd;
  logic          rle_pend;
  logic [6:0]    rle_cnt;
  logic [6:0]    rep;

  logic          q_in_ready;
  logic          q_out_valid;
  logic [8:0]    q_out_data;
  logic [CW-1:0] q_count;

  ////////////////////////////////////////////////////////////////////////////////
  // host decode

  wire dma_acc  = ~dack_n;
  wire io_hit   = ~aen & dack_n;
  wire rd_edge  = ~io_rd_n & rd_q;
  wire wr_edge  = ~io_wr_n & wr_q;
  wire sel_data = io_hit & (io_addr == `ECPPC_OFS_DATA);
  wire sel_stat = io_hit & (io_addr == `ECPPC_OFS_STAT);
  wire sel_ctl  = io_hit & (io_addr == `ECPPC_OFS_CTL);
  wire sel_fifo = dma_acc | (io_hit & (io_addr == `ECPPC_OFS_FIFO));
  wire sel_cfgb = io_hit & (io_addr == `ECPPC_OFS_CFGB) & (mode == ecppc_pkg::ECPPC_CFG);
  wire sel_xctl = io_hit & (io_addr == `ECPPC_OFS_XCTL);
  wire sel_any  = sel_data | sel_stat | sel_ctl | sel_fifo | (io_hit & (io_addr == `ECPPC_OFS_CFGB)) | sel_xctl;

  wire dir      = ctl[`ECPPC_CTL_DIR];
  wire m_ecp    = (mode == ecppc_pkg::ECPPC_ECP);
  wire m_pfifo  = (mode == ecppc_pkg::ECPPC_PFIFO);
  wire m_test   = (mode == ecppc_pkg::ECPPC_TEST);
  wire m_cfg    = (mode == ecppc_pkg::ECPPC_CFG);
  wire m_std    = (mode == ecppc_pkg::ECPPC_STD);
  wire m_bidir  = (mode == ecppc_pkg::ECPPC_BIDIR);
  // fifo mode ignores direction: always out
  wire fwd_on   = m_pfifo | (m_ecp & ~dir);
  wire rev_on   = m_ecp & dir & ~perror;

  // address view tags the byte as command, the tag lives beside the word
  wire addr_push = wr_edge & sel_data & m_ecp & ~dir;
  wire host_push = addr_push | (wr_edge & sel_fifo & (fwd_on | m_test));
  wire host_pop  = rd_edge & sel_fifo & ((m_ecp & dir) | m_test);
  wire fwd_pop   = (fs == ecppc_pkg::F_IDLE) & fwd_on & q_out_valid & ~busy;
  wire cab_push  = ((rs == ecppc_pkg::R_HOLD) & ack_n & ~rev_cmd & ~rle_pend) |
                   (rs == ecppc_pkg::R_REPEAT);
  wire q_in_valid = host_push | cab_push;
  wire [7:0] cab_byte = rev_byte;
  wire [8:0] q_in_data = host_push ? {addr_push, io_wdata} : {1'b0, cab_byte};
  wire q_full  = ~q_in_ready;
  wire q_empty = ~q_out_valid;
  wire flush   = wr_edge & sel_xctl & (io_wdata[7:6] == 2'b00);

  wire [7:0] stat_val = {~busy, ack_n, perror, select, fault_n, 3'b000};
  wire [7:0] ctl_val  = {2'b00, ctl};
  wire [7:0] cfgb_val = {`ECPPC_COMPRESS, irq_level, 6'h00};
  wire [7:0] xctl_val = {mode, err_dis, dma_en, svc, q_full, q_empty};
  // an empty queue rereads the last byte instead of stalling the bus
  wire [7:0] fifo_val = m_cfg ? `ECPPC_CFGA_VAL :
                        (q_out_valid ? q_out_data[7:0] : last_rd);
  wire [7:0] rd_val   = sel_data ? pd_in :
                        sel_stat ? stat_val :
                        sel_ctl  ? ctl_val :
                        sel_fifo ? fifo_val :
                        sel_cfgb ? cfgb_val :
                        sel_xctl ? xctl_val : 8'h00;

  wire svc_cond = ~dma_en & ((fwd_on & (q_count <= `ECPPC_SVC_LEVEL)) |
                             (m_ecp & dir & (q_count >= `ECPPC_SVC_LEVEL)));

  ecppc_fifo #(
    .W  (9),
    .D  (`ECPPC_FIFO_D),
    .CW (CW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in_data),
    .out_valid (q_out_valid),
    .out_ready (host_pop | fwd_pop),
    .out_data  (q_out_data),
    .count     (q_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q     <= 1'b1;
      wr_q     <= 1'b1;
      ack_q    <= 1'b1;
      io_rdata <= 8'h00;
      last_rd  <= 8'h00;
    end else begin
      rd_q  <= io_rd_n;
      wr_q  <= io_wr_n;
      ack_q <= ack_n;
      if (rd_edge) begin
        io_rdata <= rd_val;
      end
      if (host_pop && q_out_valid) begin
        last_rd <= q_out_data[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl      <= `ECPPC_CTL_RST;
      data_reg <= `ECPPC_DATA_RST;
      mode     <= ecppc_pkg::ECPPC_STD;
      err_dis  <= `ECPPC_ERRN_RST;
      dma_en   <= 1'b0;
      svc      <= `ECPPC_SVC_RST;
    end else begin
      if (wr_edge && sel_ctl) begin
        ctl <= io_wdata[5:0];
      end
      if (wr_edge && sel_data && (m_std || m_bidir)) begin
        data_reg <= io_wdata;
      end
      if (wr_edge && sel_xctl) begin
        mode    <= ecppc_pkg::ecppc_mode_e'(io_wdata[7:5]);
        err_dis <= io_wdata[`ECPPC_X_ERRN];
        dma_en  <= io_wdata[`ECPPC_X_DMA];
      end
      // hardware set wins over a software clear in the same cycle
      svc <= svc_cond | ((wr_edge && sel_xctl) ? io_wdata[`ECPPC_X_SVC] : svc);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_irq <= 1'b0;
      err_irq <= 1'b0;
      svc_irq <= 1'b0;
    end else begin
      ack_irq <= ctl[`ECPPC_CTL_ACKEN] & ack_n & ~ack_q;
      err_irq <= ~err_dis & m_ecp & ~fault_n;
      svc_irq <= svc & ~dma_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // forward engine: compat pulses a fixed strobe, ecp interlocks on busy

  always_comb begin
    next_fs = fs;
    case (fs)
      ecppc_pkg::F_IDLE: begin
        if (fwd_pop) begin
          next_fs = ecppc_pkg::F_SETUP;
        end
      end
      ecppc_pkg::F_SETUP: begin
        if (tmr >= SETUP_CYC - 5'h01) begin
          next_fs = ecppc_pkg::F_STROBE;
        end
      end
      ecppc_pkg::F_STROBE: begin
        if (m_ecp ? busy : (tmr >= STROBE_CYC - 5'h01)) begin
          next_fs = ecppc_pkg::F_RELEASE;
        end
      end
      ecppc_pkg::F_RELEASE: begin
        if (!m_ecp || !busy) begin
          next_fs = ecppc_pkg::F_IDLE;
        end
      end
      default: next_fs = ecppc_pkg::F_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !fwd_on) begin
      fs       <= ecppc_pkg::F_IDLE;
      tmr      <= 5'h00;
      fwd_byte <= 8'h00;
      fwd_tag  <= 1'b0;
    end else begin
      fs  <= next_fs;
      tmr <= (next_fs != fs) ? 5'h00 : tmr + 5'h01;
      if (fwd_pop) begin
        fwd_byte <= q_out_data[7:0];
        fwd_tag  <= q_out_data[8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reverse engine with run-length expansion

  // a pending count must not block the fetch of the data byte it applies to
  wire rev_go = (rs == ecppc_pkg::R_IDLE) & rev_on & q_in_ready;

  always_comb begin
    next_rs = rs;
    case (rs)
      ecppc_pkg::R_IDLE: begin
        if (rev_go) begin
          next_rs = ecppc_pkg::R_REQ;
        end
      end
      ecppc_pkg::R_REQ: begin
        if (!ack_n) begin
          next_rs = ecppc_pkg::R_HOLD;
        end
      end
      ecppc_pkg::R_HOLD: begin
        if (ack_n) begin
          next_rs = (!rev_cmd && rle_pend) ? ecppc_pkg::R_REPEAT : ecppc_pkg::R_IDLE;
        end
      end
      ecppc_pkg::R_REPEAT: begin
        if (q_in_ready && rep == 7'h00) begin
          next_rs = ecppc_pkg::R_IDLE;
        end
      end
      default: next_rs = ecppc_pkg::R_IDLE;
    endcase
  end

  // rle_pend only holds the count; the data byte after it starts the repeat
  wire rle_hit = (rs == ecppc_pkg::R_HOLD) & ack_n & rev_cmd & ~rev_byte[`ECPPC_TAG_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n || !(m_ecp && dir)) begin
      rs       <= ecppc_pkg::R_IDLE;
      rev_byte <= 8'h00;
      rev_cmd  <= 1'b0;
      rle_pend <= 1'b0;
      rle_cnt  <= 7'h00;
      rep      <= 7'h00;
    end else begin
      rs <= next_rs;
      if (rs == ecppc_pkg::R_REQ && !ack_n) begin
        rev_byte <= pd_in;
        rev_cmd  <= ~busy;
      end
      if (rle_hit) begin
        rle_pend <= 1'b1;
        rle_cnt  <= rev_byte[6:0];
      end
      if (rs == ecppc_pkg::R_HOLD && ack_n && !rev_cmd && rle_pend) begin
        rep <= rle_cnt;
      end else if (rs == ecppc_pkg::R_REPEAT && q_in_ready) begin
        rep <= rep - 7'h01;
        if (rep == 7'h00) begin
          rle_pend <= 1'b0;
        end
      end
    end
  end

  // rev_go waits for room, so a repeat stalls only on rle bursts
  wire rle_ok = (rs != ecppc_pkg::R_REPEAT) | rle_pend;

  ////////////////////////////////////////////////////////////////////////////////
  // cable pins

  wire fwd_busy = (fs != ecppc_pkg::F_IDLE);
  wire drive    = m_std | m_pfifo | (m_ecp ? (~dir & perror) : ~dir);

  assign pd_out      = fwd_busy ? fwd_byte : data_reg;
  assign pd_oe_n     = ~drive;
  assign strobe_n    = (m_ecp | m_pfifo) ? (fs != ecppc_pkg::F_STROBE) : ~ctl[`ECPPC_CTL_STB];
  assign autofd_n    = m_ecp ? (dir ? (rs != ecppc_pkg::R_REQ) : ~fwd_tag)
                             : ~ctl[`ECPPC_CTL_AFD];
  assign init_n      = m_ecp ? ~dir : ctl[`ECPPC_CTL_INIT];
  assign select_in_n = ~ctl[`ECPPC_CTL_SELIN];
  assign io_rdata_oe_n = ~(~io_rd_n & sel_any);
  assign drq = dma_en & ((fwd_on & q_in_ready) | (m_ecp & dir & q_out_valid));

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_cfga_const: assert property (rd_edge && sel_fifo && m_cfg && io_hit |=> io_rdata == 8'h10)
    else $error("config word a wrong");
  a_stat_busy: assert property (rd_edge && sel_stat |=> io_rdata[7] == !$past(busy) &&
                                io_rdata[2:0] == 3'b000)
    else $error("status busy bit wrong");
  a_ctl_top_zero: assert property (rd_edge && sel_ctl |=> io_rdata[7:6] == 2'b00)
    else $error("control high bits not zero");
  a_flag_track: assert property (q_full == (q_count == 5'h10) && q_empty == (q_count == 5'h00))
    else $error("queue flags out of step");
  a_strobe_busy: assert property (fwd_pop |-> !busy ##1 fs == ecppc_pkg::F_SETUP)
    else $error("strobe started while busy");
  a_fwd_hostack: assert property (m_ecp && !dir && !strobe_n |-> autofd_n == !fwd_tag)
    else $error("host ack tag wrong");
  a_init_dir: assert property (m_ecp |-> init_n == !dir)
    else $error("init does not follow direction");
  a_rev_nodrive: assert property (m_ecp && dir |-> pd_oe_n)
    else $error("data driven in reverse");
  a_rle_end: assert property (rs == ecppc_pkg::R_REPEAT && q_in_ready && rep == 7'h00 && rle_ok
                              |=> rs == ecppc_pkg::R_IDLE && !rle_pend)
    else $error("repeat did not finish");
  a_compat_width: assert property ($fell(strobe_n) && m_pfifo |-> !strobe_n [*8])
    else $error("compat strobe too short");

endmodule

// >>> ecppc_periph.sv
// behavioural cable peripheral for the ecp parallel port core
// assumes the core's cable pins; reverse bytes are queued by send()
`timescale 1ns/1ps
module ecppc_periph (
  input  wire logic       clk,
  input  wire logic [7:0] pd_out,
  input  wire logic       pd_oe_n,
  input  wire logic       strobe_n,
  input  wire logic       autofd_n,
  input  wire logic       init_n,
  input  wire logic       select_in_n,
  output logic      [7:0] pd_in,
  output logic            busy,
  output logic            ack_n,
  output logic            perror,
  output logic            cap_stb,
  output logic      [8:0] cap_word,
  output logic            viol
);
  logic [8:0] rev_q[$];
  logic [8:0] w;
  logic       drive;

  function automatic void send(input logic [8:0] v);
    rev_q.push_back(v);
  endfunction

  // released lines show the inverse, so a stale byte never passes
  assign pd_in = drive ? w[7:0] : ~pd_out;

  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    perror = 1'b1;
    cap_stb = 1'b0;
    cap_word = 9'h000;
    viol = 1'b0;
    drive = 1'b0;
    w = 9'h000;
  end

  always @(posedge clk) perror <= init_n;

  ////////////////////////////////////////////////////////////////////////////////
  initial forever begin
    @(negedge strobe_n);
    if (busy) viol = 1'b1;
    @(posedge clk);
    #2;
    cap_word = {autofd_n, pd_out};
    busy = 1'b1;
    cap_stb = 1'b1;
    @(posedge clk);
    #2 cap_stb = 1'b0;
    // ecp strobe may already be back high here
    if (!strobe_n) @(posedge strobe_n);
    repeat (3) @(posedge clk);
    #2 busy = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial forever begin
    @(posedge clk);
    #2;
    if (!init_n && !perror && !autofd_n && select_in_n && rev_q.size() > 0) begin
      w = rev_q.pop_front();
      drive = 1'b1;
      busy = w[8];
      if (!pd_oe_n) viol = 1'b1;
      repeat (2) @(posedge clk);
      #2 ack_n = 1'b0;
      @(posedge autofd_n);
      @(posedge clk);
      #2 ack_n = 1'b1;
      repeat (2) @(posedge clk);
      #2 drive = 1'b0;
      busy = 1'b0;
    end
  end
endmodule

// >>> ecppc_core_tb.sv
// self-checking bench for ecppc_core with the cable peripheral model
// assumes 40 MHz clk; expectations queued, checked by a watcher process
`timescale 1ns/1ps
module ecppc_core_tb;
  logic        clk, rst_n, aen, io_rd_n, io_wr_n, dack_n, irq_level, select, fault_n;
  logic [10:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, pd_in, pd_out, r;
  logic        io_rdata_oe_n, drq, ack_irq, err_irq, svc_irq, pd_oe_n;
  logic        strobe_n, autofd_n, init_n, select_in_n, busy, ack_n, perror, cap_stb, viol;
  logic [8:0]  cap_word;
  logic [15:0] rd_q[$];
  logic [8:0]  cap_q[$];
  logic [7:0]  tq[$];
  int          failures, checks, n, acks;

  ecppc_core i_dut (.clk, .rst_n, .aen, .io_addr, .io_rd_n, .io_wr_n, .io_wdata, .io_rdata,
    .io_rdata_oe_n, .drq, .dack_n, .irq_level, .ack_irq, .err_irq, .svc_irq, .pd_in, .pd_out,
    .pd_oe_n, .strobe_n, .autofd_n, .init_n, .select_in_n, .busy, .ack_n, .perror, .select, .fault_n);
  ecppc_periph i_per (.clk, .pd_out, .pd_oe_n, .strobe_n, .autofd_n, .init_n, .select_in_n,
    .pd_in, .busy, .ack_n, .perror, .cap_stb, .cap_word, .viol);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic dma = 1'b0);
    @(posedge clk);
    #2 io_addr = a;
    io_wdata = d;
    dack_n = ~dma;
    io_wr_n = 1'b0;
    @(posedge clk);
    #2 io_wr_n = 1'b1;
    dack_n = 1'b1;
  endtask

  task automatic rd(input logic [10:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    #2 io_addr = a;
    rd_q.push_back({m, e & m});
    io_rd_n = 1'b0;
    #1 chk("io_rdata_oe_n", {8'h00, io_rdata_oe_n}, {8'h00, a == 11'h003});
    @(posedge clk);
    #2 io_rd_n = 1'b1;
  endtask

  // bounded wait until every cable transfer has landed
  task automatic settle;
    n = 0;
    while ((cap_q.size() > 0 || i_per.rev_q.size() > 0) && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      failures++;
      stop_test();
    end
    repeat (40) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial fork
    forever begin
      @(posedge io_rd_n);
      #1 chk("io_rdata", {1'b0, io_rdata & rd_q[0][15:8]}, {1'b0, rd_q[0][7:0]});
      void'(rd_q.pop_front());
    end
    forever begin
      @(posedge cap_stb);
      #1 chk("cable byte", cap_word, cap_q.pop_front());
    end
    forever begin
      @(posedge clk);
      if (ack_irq === 1'b1) acks++;
    end
  join

  initial begin
    void'($urandom(32'h4774));
    rst_n = 1'b0;
    aen = 1'b0;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    dack_n = 1'b1;
    irq_level = 1'($urandom);
    select = 1'($urandom);
    fault_n = 1'b1;
    io_addr = 11'h000;
    io_wdata = 8'h00;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    rd(11'h002, 8'h00);
    rd(11'h001, {3'b110, select, 4'h8});
    rd(11'h402, 8'h15);
    rd(11'h003, 8'h00);
    rd(11'h401, 8'h00);
    wr(11'h002, 8'h04);
    // address not valid: the write must be ignored
    aen = 1'b1;
    wr(11'h002, 8'h3F);
    aen = 1'b0;
    rd(11'h002, 8'h04);
    for (int m = 0; m < 8; m++) begin
      wr(11'h402, {3'(m), 5'h10});
      rd(11'h402, {3'(m), 5'h00}, 8'hE0);
      rd(11'h002, 8'h04);
      rd(11'h001, {3'b111, select, 4'h8});
    end
    wr(11'h402, 8'hF0);
    rd(11'h400, 8'h10);
    rd(11'h401, {1'b0, irq_level, 6'h00});
    // test view: overfill, then underrun rereads the last byte
    wr(11'h402, 8'hD0);
    for (int i = 0; i < 17; i++) begin
      r = 8'($urandom);
      if (i < 16) tq.push_back(r);
      wr(11'h400, r);
    end
    rd(11'h402, 8'h02, 8'h03);
    for (int i = 0; i < 16; i++) rd(11'h400, tq[i]);
    rd(11'h400, tq[15]);
    rd(11'h402, 8'h01, 8'h03);
    wr(11'h402, 8'h10);
    r = 8'($urandom);
    wr(11'h000, r);
    repeat (2) @(posedge clk);
    #2 chk("pd_out", {1'b0, pd_out}, {1'b0, r});
    chk("pd_oe_n", {8'h00, pd_oe_n}, 9'h000);
    // ecp forward: address tag, host write, dma write
    wr(11'h402, 8'h60);
    cap_q.push_back(9'h085);
    cap_q.push_back(9'h112);
    cap_q.push_back(9'h134);
    wr(11'h000, 8'h85);
    wr(11'h400, 8'h12);
    wr(11'h402, 8'h68);
    chk("drq", {8'h00, drq}, 9'h001);
    wr(11'h400, 8'h34, 1'b1);
    wr(11'h402, 8'h60);
    settle();
    chk("svc_irq", {8'h00, svc_irq}, 9'h001);
    @(posedge clk);
    #2 fault_n = 1'b0;
    repeat (4) @(posedge clk);
    #2 chk("err_irq", {8'h00, err_irq}, 9'h001);
    wr(11'h402, 8'h70);
    repeat (3) @(posedge clk);
    #2 chk("err_irq", {8'h00, err_irq}, 9'h000);
    fault_n = 1'b1;
    // compatibility fifo: no software strobes
    wr(11'h402, 8'h50);
    cap_q.push_back(9'h177);
    cap_q.push_back(9'h188);
    wr(11'h400, 8'h77);
    wr(11'h400, 8'h88);
    settle();
    // ecp reverse: channel address dropped, count 2 gives three copies
    wr(11'h402, 8'h70);
    i_per.send(9'h081);
    i_per.send(9'h002);
    i_per.send(9'h1A5);
    i_per.send(9'h13C);
    // reverse with ack interrupt enabled: one pulse per peripheral byte
    wr(11'h002, 8'h30);
    settle();
    chk("pd_oe_n", {8'h00, pd_oe_n}, 9'h001);
    for (int i = 0; i < 3; i++) rd(11'h400, 8'hA5);
    rd(11'h400, 8'h3C);
    rd(11'h402, 8'h01, 8'h03);
    wr(11'h002, 8'h04);
    repeat (10) @(posedge clk);
    chk("ack_irq pulses", 9'(acks), 9'h004);
    chk("queues drained", 9'(rd_q.size() + cap_q.size()), 9'h000);
    chk("peripheral protocol", {8'h00, viol}, 9'h000);
    stop_test();
  end
endmodule
